//--- design/dual_echo_pkg.sv
// shared constants and types for the dual echo pcm serial port
package dual_echo_pkg;
   localparam int CLK_PERIOD_NS   = 25;
   localparam int FRAME_PERIOD_NS = 125000;
   localparam int FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MIN_RATE_KBPS   = 128;
   localparam int MAX_RATE_KBPS   = 4096;
   // shortest half bit at the top rate; the edge finder needs two samples
   localparam int HALF_BIT_NS     = 1000000 / (2 * MAX_RATE_KBPS);
   localparam int HALF_BIT_CYCLES = HALF_BIT_NS / CLK_PERIOD_NS;

   localparam logic [4:0] WORD_NARROW = 5'h08;
   localparam logic [4:0] WORD_WIDE   = 5'h10;
   localparam logic [4:0] CNT_MAX     = 5'h1f;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BPTAB  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [3:0] ADDR_RAW_HI = 4'h1;
   localparam logic [3:0] ADDR_LIN_HI = 4'h2;

   localparam int CTRL_STROBED = 0;
   localparam int CTRL_ALAW    = 1;
   localparam int CTRL_ITU     = 2;
   localparam int CTRL_LINEAR  = 3;
   localparam logic [3:0] CTRL_RESET  = 4'h5;
   localparam logic [7:0] BPTAB_RESET = 8'he4;
   localparam int ST_ERR = 6;

   localparam int SY_BCLK = 0;
   localparam int SY_SAR  = 1;
   localparam int SY_SBR  = 2;
   localparam int SY_SAS  = 3;
   localparam int SY_SBS  = 4;
   localparam int SY_RIN  = 5;
   localparam int SY_SIN  = 6;
   localparam int SY_FRM  = 7;
   localparam int SY_PD   = 8;

   localparam logic [7:0] MU_BIAS  = 8'h84;
   localparam logic [8:0] A_BIAS   = 9'h108;
   localparam logic [7:0] A_TOGGLE = 8'h55;

   typedef enum logic [1:0] {LS_IDLE, LS_SLOT, LS_WAIT} lane_state_e;
endpackage

//--- design/pcm_lane_if.sv
// signals between the port top and one serial lane
`timescale 1ns/1ps
interface pcm_lane_if;
   logic        rise;
   logic        fall;
   logic        frame;
   logic        strobe_a;
   logic        strobe_b;
   logic        din;
   logic        backplane;
   logic [1:0]  submode;
   logic [15:0] tx_a;
   logic [15:0] tx_b;
   logic        dout;
   logic        done;
   logic        chan;
   logic [15:0] word;
   logic        len16;
   logic        werr;
   modport lane (input rise, fall, frame, strobe_a, strobe_b, din,
                 backplane, submode, tx_a, tx_b,
                 output dout, done, chan, word, len16, werr);
   modport port (output rise, fall, frame, strobe_a, strobe_b, din,
                 backplane, submode, tx_a, tx_b,
                 input dout, done, chan, word, len16, werr);
endinterface

//--- design/pcm_lane.sv
// one serial lane: slot framing, bit capture and bit drive
`timescale 1ns/1ps
module pcm_lane
(
   input wire logic clk,
   input wire logic rst,
   pcm_lane_if.lane io
);
   typedef struct packed {
      dual_echo_pkg::lane_state_e st;
      logic                       chan;
      logic [15:0]                rx_sh;
      logic [15:0]                tx_sh;
      logic [4:0]                 cnt;
      logic                       dout;
      logic                       done;
      logic                       werr;
      logic [15:0]                word;
      logic                       len16;
   } lane_s;

   lane_s       r_q;
   lane_s       r_d;
   logic        samp;
   logic        drv;
   logic        act;
   logic        load;
   logic        load_chan;
   logic [4:0]  width;
   logic [15:0] txw;

   assign io.dout  = r_q.dout;
   assign io.done  = r_q.done;
   assign io.chan  = r_q.chan;
   assign io.word  = r_q.word;
   assign io.len16 = r_q.len16;
   assign io.werr  = r_q.werr;

   always_comb
   begin
      r_d      = r_q;
      r_d.done = 1'b0;
      r_d.werr = 1'b0;
      load      = 1'b0;
      load_chan = 1'b0;
      // backplane sub-mode bit 1 picks word width, bit 0 the sample edge
      width = (io.backplane & io.submode[1]) ? dual_echo_pkg::WORD_WIDE
                                             : dual_echo_pkg::WORD_NARROW;
      samp  = (io.backplane & io.submode[0]) ? io.rise : io.fall;
      drv   = (io.backplane & io.submode[0]) ? io.fall : io.rise;
      act   = io.backplane ? (r_q.st == dual_echo_pkg::LS_SLOT)
                           : (io.strobe_a | io.strobe_b);
      if (r_q.st == dual_echo_pkg::LS_SLOT && act)
      begin
         if (samp)
         begin
            r_d.rx_sh = {r_q.rx_sh[14:0], io.din};
            if (r_q.cnt != dual_echo_pkg::CNT_MAX)
               r_d.cnt = r_q.cnt + 5'h01;
         end
         if (drv)
         begin
            r_d.dout  = r_q.tx_sh[15];
            r_d.tx_sh = {r_q.tx_sh[14:0], 1'b0};
         end
      end
      case (r_q.st)
         dual_echo_pkg::LS_IDLE:
            if (!io.backplane && act)
            begin
               load      = 1'b1;
               load_chan = io.strobe_b;
            end
         dual_echo_pkg::LS_SLOT:
            if (!io.backplane && !act)
            begin
               r_d.st = dual_echo_pkg::LS_IDLE;
               // a slot that is neither 8 nor 16 bits is dropped
               if (r_q.cnt == dual_echo_pkg::WORD_NARROW ||
                   r_q.cnt == dual_echo_pkg::WORD_WIDE)
               begin
                  r_d.done  = 1'b1;
                  r_d.len16 = (r_q.cnt == dual_echo_pkg::WORD_WIDE);
                  r_d.word  = r_d.len16 ? r_q.rx_sh
                                        : {8'h00, r_q.rx_sh[7:0]};
               end
               else
                  r_d.werr = 1'b1;
            end
            else if (io.backplane && samp && r_q.cnt + 5'h01 == width)
            begin
               r_d.done  = 1'b1;
               r_d.len16 = io.submode[1];
               r_d.word  = io.submode[1] ? {r_q.rx_sh[14:0], io.din}
                                         : {8'h00, r_q.rx_sh[6:0], io.din};
               if (!r_q.chan)
               begin
                  load      = 1'b1;
                  load_chan = 1'b1;
               end
               else
                  r_d.st = dual_echo_pkg::LS_WAIT;
            end
         dual_echo_pkg::LS_WAIT:
            if (!io.backplane)
               r_d.st = dual_echo_pkg::LS_IDLE;
         default:
            r_d.st = dual_echo_pkg::LS_IDLE;
      endcase
      if (io.backplane && io.frame)
      begin
         load      = 1'b1;
         load_chan = 1'b0;
      end
      txw = load_chan ? io.tx_b : io.tx_a;
      if (load)
      begin
         r_d.st    = dual_echo_pkg::LS_SLOT;
         r_d.chan  = load_chan;
         r_d.cnt   = 5'h00;
         r_d.dout  = txw[15];
         r_d.tx_sh = {txw[14:0], 1'b0};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   property p_strobe_b_slot;
      @(posedge clk) disable iff (rst)
      (!io.backplane && r_q.st == dual_echo_pkg::LS_IDLE && io.strobe_b)
         |=> (r_q.st == dual_echo_pkg::LS_SLOT && r_q.chan);
   endproperty
   a_strobe_b_slot: assert property (p_strobe_b_slot)
      else $error("second strobe did not open a second-channel slot");

   property p_strobe_a_slot;
      @(posedge clk) disable iff (rst)
      (!io.backplane && r_q.st == dual_echo_pkg::LS_IDLE && io.strobe_a
       && !io.strobe_b)
         |=> (r_q.st == dual_echo_pkg::LS_SLOT && !r_q.chan);
   endproperty
   a_strobe_a_slot: assert property (p_strobe_a_slot)
      else $error("first strobe did not open a first-channel slot");

   property p_slot_end;
      @(posedge clk) disable iff (rst)
      (!io.backplane && r_q.st == dual_echo_pkg::LS_SLOT
       && !io.strobe_a && !io.strobe_b)
         |=> ((r_q.done ^ r_q.werr) && r_q.st == dual_echo_pkg::LS_IDLE);
   endproperty
   a_slot_end: assert property (p_slot_end)
      else $error("strobed slot end gave no word and no width error");

   property p_bp_second;
      @(posedge clk) disable iff (rst)
      (io.backplane && r_q.done && r_q.st == dual_echo_pkg::LS_SLOT)
         |-> (r_q.chan && r_q.cnt == 5'h00);
   endproperty
   a_bp_second: assert property (p_bp_second)
      else $error("backplane first word did not hand over to second");
endmodule

//--- design/dual_echo_pcm_serial_port.sv
// serial pcm port of a dual channel echo canceller with apb registers
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module dual_echo_pcm_serial_port
#(
   parameter int FRAME_LIMIT = 2 * dual_echo_pkg::FRAME_CYCLES
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output wire logic [31:0] PRDATA,
   output wire logic        PREADY,
   output wire logic        PSLVERR,
   input  wire logic        BIT_CLK,
   input  wire logic        STROBE_A_RECEIVE_PATH,
   input  wire logic        STROBE_B_RECEIVE_PATH,
   input  wire logic        STROBE_A_SEND_PATH,
   input  wire logic        STROBE_B_SEND_PATH,
   input  wire logic        RECEIVE_IN,
   input  wire logic        SEND_IN,
   input  wire logic        BP_FRAME_N,
   input  wire logic        POWER_DOWN_N,
   output wire logic        SEND_OUT,
   output wire logic        RECEIVE_OUT,
   output wire logic        STANDBY
);
   typedef struct packed {
      logic [8:0]       s1;
      logic [8:0]       s2;
      logic             bclk_p;
      logic             frame_p;
      logic             sar_p;
      logic [3:0]       ctrl;
      logic [7:0]       bptab;
      logic             err;
      logic [13:0]      fcnt;
      logic             synced;
      logic [3:0][16:0] words;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
      logic             send_out;
      logic             recv_out;
      logic             standby;
   } port_s;

   port_s       r_q;
   port_s       r_d;
   logic        lane_rst;
   logic        strobed;
   logic        bclk_rise;
   logic        bclk_fall;
   logic        frame_ev;
   logic        access;
   logic [1:0]  done_w;
   logic [1:0]  chan_w;
   logic [1:0]  len_w;
   logic [1:0]  werr_w;
   logic [1:0]  dout_w;
   logic [1:0]  rx_mode;
   logic [1:0]  tx_mode;
   logic [15:0] word_w [2];
   logic [31:0] rd;
   logic        bad;

   pcm_lane_if lane_io[2] ();

   // 16-bit words are sent as is; 8-bit ones move from the low byte to the high byte
   function automatic logic [15:0] align(input logic [16:0] w);
      align = w[16] ? w[15:0] : {w[7:0], 8'h00};
   endfunction

   function automatic logic [15:0] to_linear(input logic [16:0] w,
                                             input logic [3:0]  c);
      logic [7:0]  code;
      logic        neg;
      logic [2:0]  e;
      logic [3:0]  m;
      logic [15:0] mag;
      code = w[7:0];
      neg  = code[7];
      if (c[dual_echo_pkg::CTRL_ITU])
      begin
         code = c[dual_echo_pkg::CTRL_ALAW] ? code ^ dual_echo_pkg::A_TOGGLE
                                            : ~code;
         neg  = ~code[7];
      end
      e = code[6:4];
      m = code[3:0];
      if (c[dual_echo_pkg::CTRL_ALAW])
         mag = (e == 3'h0) ? {8'h00, m, 4'h8}
               : ({7'h00, dual_echo_pkg::A_BIAS} + {8'h00, m, 4'h0})
                 << (e - 3'h1);
      else
         mag = (({8'h00, dual_echo_pkg::MU_BIAS} + {9'h000, m, 3'h0}) << e)
               - {8'h00, dual_echo_pkg::MU_BIAS};
      to_linear = neg ? 16'h0000 - mag : mag;
      if (c[dual_echo_pkg::CTRL_LINEAR])
         to_linear = align(w);
   endfunction

   assign strobed   = r_q.ctrl[dual_echo_pkg::CTRL_STROBED];
   assign bclk_rise = r_q.s2[dual_echo_pkg::SY_BCLK] & ~r_q.bclk_p;
   assign bclk_fall = ~r_q.s2[dual_echo_pkg::SY_BCLK] & r_q.bclk_p;
   assign frame_ev  = strobed
      ? (r_q.s2[dual_echo_pkg::SY_SAR] & ~r_q.sar_p)
      : (~r_q.s2[dual_echo_pkg::SY_FRM] & r_q.frame_p);
   assign lane_rst  = SYS_RST | r_q.standby;
   assign access    = PSEL & PENABLE;
   assign rx_mode   = r_q.bptab[{r_q.s2[dual_echo_pkg::SY_SBR],
                                 r_q.s2[dual_echo_pkg::SY_SAR], 1'b0} +: 2];
   assign tx_mode   = r_q.bptab[{r_q.s2[dual_echo_pkg::SY_SBS],
                                 r_q.s2[dual_echo_pkg::SY_SAS], 1'b0} +: 2];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_lane
         localparam int SA  = (g == 0) ? dual_echo_pkg::SY_SAR
                                       : dual_echo_pkg::SY_SAS;
         localparam int SB  = (g == 0) ? dual_echo_pkg::SY_SBR
                                       : dual_echo_pkg::SY_SBS;
         localparam int DI  = (g == 0) ? dual_echo_pkg::SY_RIN
                                       : dual_echo_pkg::SY_SIN;
         localparam int SRC = (1 - g) * 2;
         assign lane_io[g].rise      = bclk_rise;
         assign lane_io[g].fall      = bclk_fall;
         assign lane_io[g].frame     = ~strobed & frame_ev;
         assign lane_io[g].strobe_a  = r_q.s2[SA];
         assign lane_io[g].strobe_b  = r_q.s2[SB];
         assign lane_io[g].din       = r_q.s2[DI];
         assign lane_io[g].backplane = ~strobed;
         assign lane_io[g].submode   = (g == 0) ? rx_mode : tx_mode;
         // each output slot carries the other stream's word, same channel
         assign lane_io[g].tx_a      = align(r_q.words[SRC]);
         assign lane_io[g].tx_b      = align(r_q.words[SRC + 1]);
         assign done_w[g]            = lane_io[g].done;
         assign chan_w[g]            = lane_io[g].chan;
         assign len_w[g]             = lane_io[g].len16;
         assign werr_w[g]            = lane_io[g].werr;
         assign dout_w[g]            = lane_io[g].dout;
         assign word_w[g]            = lane_io[g].word;
         pcm_lane u_lane
         (
            .clk (CORE_CLK),
            .rst (lane_rst),
            .io  (lane_io[g])
         );
      end
   endgenerate

   always_comb
   begin
      r_d = r_q;
      // two flops per pin; the second stage alone feeds the logic
      r_d.s1 = {POWER_DOWN_N, BP_FRAME_N, SEND_IN, RECEIVE_IN,
                STROBE_B_SEND_PATH, STROBE_A_SEND_PATH,
                STROBE_B_RECEIVE_PATH, STROBE_A_RECEIVE_PATH, BIT_CLK};
      r_d.s2      = r_q.s1;
      r_d.bclk_p  = r_q.s2[dual_echo_pkg::SY_BCLK];
      r_d.frame_p = r_q.s2[dual_echo_pkg::SY_FRM];
      r_d.sar_p   = r_q.s2[dual_echo_pkg::SY_SAR];
      r_d.standby = ~r_q.s2[dual_echo_pkg::SY_PD];
      // frame lock drops after two frames without the frame reference
      if (frame_ev)
      begin
         r_d.fcnt   = 14'h0000;
         r_d.synced = 1'b1;
      end
      else if (r_q.fcnt != 14'(FRAME_LIMIT))
         r_d.fcnt = r_q.fcnt + 14'h0001;
      else
         r_d.synced = 1'b0;
      for (int i = 0; i < 2; i++)
         if (done_w[i])
            r_d.words[i * 2 + int'(chan_w[i])] = {len_w[i], word_w[i]};
      r_d.send_out = dout_w[0] & ~r_q.standby;
      r_d.recv_out = dout_w[1] & ~r_q.standby;

      rd  = 32'h0000_0000;
      bad = 1'b0;
      case (PADDR)
         dual_echo_pkg::ADDR_CTRL:   rd = {28'h0000000, r_q.ctrl};
         dual_echo_pkg::ADDR_BPTAB:  rd = {24'h000000, r_q.bptab};
         dual_echo_pkg::ADDR_STATUS:
            rd = {25'h0000000, r_q.err, tx_mode, rx_mode,
                  r_q.standby, r_q.synced};
         default:
            if (PADDR[1:0] != 2'h0)
               bad = 1'b1;
            else if (PADDR[7:4] == dual_echo_pkg::ADDR_RAW_HI)
               rd = {15'h0000, r_q.words[PADDR[3:2]]};
            else if (PADDR[7:4] == dual_echo_pkg::ADDR_LIN_HI)
               rd = {16'h0000, to_linear(r_q.words[PADDR[3:2]], r_q.ctrl)};
            else
               bad = 1'b1;
      endcase
      r_d.pready = access & ~r_q.pready;
      if (access & ~r_q.pready)
      begin
         r_d.prdata  = PWRITE ? 32'h0000_0000 : rd;
         r_d.pslverr = bad;
      end
      // set wins over a same-cycle write-one clear
      r_d.err = r_q.err;
      if (access & r_q.pready & PWRITE & ~bad)
      begin
         if (PADDR == dual_echo_pkg::ADDR_CTRL)
            r_d.ctrl = PWDATA[3:0];
         if (PADDR == dual_echo_pkg::ADDR_BPTAB)
            r_d.bptab = PWDATA[7:0];
         if (PADDR == dual_echo_pkg::ADDR_STATUS &&
             PWDATA[dual_echo_pkg::ST_ERR])
            r_d.err = 1'b0;
      end
      if (|werr_w)
         r_d.err = 1'b1;
      if (r_q.standby)
      begin
         r_d.words  = '0;
         r_d.synced = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         r_q       <= '0;
         r_q.ctrl  <= dual_echo_pkg::CTRL_RESET;
         r_q.bptab <= dual_echo_pkg::BPTAB_RESET;
         // power-down pin idles high; no false standby after reset
         r_q.s1[dual_echo_pkg::SY_PD] <= 1'b1;
         r_q.s2[dual_echo_pkg::SY_PD] <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   assign PRDATA      = r_q.prdata;
   assign PREADY      = r_q.pready;
   assign PSLVERR     = r_q.pslverr;
   assign SEND_OUT    = r_q.send_out;
   assign RECEIVE_OUT = r_q.recv_out;
   assign STANDBY     = r_q.standby;

   property p_frame_lock;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (frame_ev && !r_q.standby) |=> (r_q.synced && r_q.fcnt == 14'h0000);
   endproperty
   a_frame_lock: assert property (p_frame_lock)
      else $error("frame reference did not restart the frame lock");

   property p_standby;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      !r_q.s2[dual_echo_pkg::SY_PD]
         |=> STANDBY ##1 (!SEND_OUT && !RECEIVE_OUT && !r_q.synced);
   endproperty
   a_standby: assert property (p_standby)
      else $error("power-down did not force standby and quiet outputs");

   property p_store_rx;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (done_w[0] && !r_q.standby)
         |=> r_q.words[{1'b0, $past(chan_w[0])}]
             == {$past(len_w[0]), $past(word_w[0])};
   endproperty
   a_store_rx: assert property (p_store_rx)
      else $error("receive-in word not stored for its canceller");

   property p_store_tx;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (done_w[1] && !r_q.standby)
         |=> r_q.words[{1'b1, $past(chan_w[1])}]
             == {$past(len_w[1]), $past(word_w[1])};
   endproperty
   a_store_tx: assert property (p_store_tx)
      else $error("send-in word not stored for its canceller");

   property p_apb_answer;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not a single cycle after access");
endmodule

//--- sim/pcm_highway_model.sv
// far-side pcm highway model: bit clock, slot strobes, serial data
`timescale 1ns/1ps
module pcm_highway_model
#(
   parameter int BIT_NS = 200
)
(
   output logic       bit_clk,
   output logic [3:0] strobe,
   output logic       rin,
   output logic       sin
);
   initial
   begin
      bit_clk = 1'b0;
      strobe  = 4'h0;
      rin     = 1'b0;
      sin     = 1'b1;
   end

   // clock pulses once more as the strobe drops, then stands still; a released line shows the inverse
   task automatic slot(input int k, input logic [15:0] w, input int n);
      logic b;
      #3;
      for (int i = n - 1; i >= 0; i--)
      begin
         b = w[i];
         bit_clk = 1'b1;
         strobe[k] = 1'b1;
         if (k < 2)
            rin = b;
         else
            sin = b;
         #(BIT_NS / 2);
         bit_clk = 1'b0;
         #(BIT_NS / 2);
      end
      bit_clk = 1'b1;
      strobe[k] = 1'b0;
      if (k < 2)
         rin = ~b;
      else
         sin = ~b;
      #(BIT_NS / 2);
      bit_clk = 1'b0;
      #(BIT_NS);
   endtask

   task automatic levels(input logic [3:0] v);
      strobe = v;
   endtask
endmodule

//--- sim/tb_dual_echo_pcm_serial_port.sv
// self-checking bench for the dual echo pcm serial port
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   checks_done++; \
   if ((got) !== (exp)) \
   begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
   end
module tb_dual_echo_pcm_serial_port;
   localparam int LIMIT = 2000;
   logic        core_clk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pwr_n;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         send_out;
   wire         recv_out;
   logic [15:0] cap;
   wire         standby;
   wire         bclk;
   wire         rin;
   wire         sin;
   wire  [3:0]  stb;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          checks_done;
   int          cycles;

   pcm_highway_model i_far (.bit_clk(bclk), .strobe(stb), .rin(rin),
      .sin(sin));
   dual_echo_pcm_serial_port #(.FRAME_LIMIT(LIMIT)) i_dut (
      .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BIT_CLK(bclk),
      .STROBE_A_RECEIVE_PATH(stb[0]), .STROBE_B_RECEIVE_PATH(stb[1]),
      .STROBE_A_SEND_PATH(stb[2]), .STROBE_B_SEND_PATH(stb[3]),
      .RECEIVE_IN(rin), .SEND_IN(sin), .BP_FRAME_N(1'b1),
      .POWER_DOWN_N(pwr_n), .SEND_OUT(send_out), .RECEIVE_OUT(recv_out),
      .STANDBY(standby));

   task automatic end_of_test;
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // slot then a fixed settle for the synchronisers and the store
   task automatic slot_rd(input int k, input logic [15:0] w, input int n,
                          input logic [7:0] a);
      i_far.slot(k, w, n);
      repeat (20) @(posedge core_clk);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic t_regs;
      apb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl", 32'h5, rd)
      apb(1'b0, 8'h04, 32'h0);
      `CHK("bptab", 32'he4, rd)
      apb(1'b1, 8'h40, 32'h1);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, 8'h10, 32'hffff);
      `CHK("ro err", 1'b0, err)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("ro word", 32'h0, rd)
   endtask

   // output bits settle some clocks after the bit clock; look late
   always @(negedge bclk)
   begin
      #80;
      if (stb[0] | stb[1])
         cap = {cap[14:0], send_out};
   end

   task automatic t_slots;
      logic [15:0] w;
      logic [31:0] e;
      for (int k = 0; k < 4; k++)
      begin
         w = 16'h3c5a ^ 16'(k);
         e = k[0] ? {15'h1, w} : {24'h0, w[7:0]};
         slot_rd(k, w, k[0] ? 16 : 8, 8'h10 + 8'(4 * k));
         `CHK("slot", e, rd)
      end
      // send-in word a now leaves on the receive-path slot a
      slot_rd(0, 16'h0000, 8, 8'h10);
      `CHK("send out", 8'h58, cap[7:0])
   endtask

   task automatic t_lock;
      slot_rd(0, 16'h81, 8, 8'h08);
      `CHK("locked", 1'b1, rd[0])
      repeat (LIMIT + 100) @(posedge core_clk);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("lock lost", 1'b0, rd[0])
   endtask

   task automatic t_width;
      slot_rd(0, 16'h1f, 5, 8'h08);
      `CHK("width err", 1'b1, rd[6])
      apb(1'b1, 8'h08, 32'h40);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("width clr", 1'b0, rd[6])
   endtask

   task automatic t_bp;
      apb(1'b1, 8'h00, 32'h4);
      i_far.levels(4'b0110);
      repeat (8) @(posedge core_clk);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("bp modes", 4'h6, rd[5:2])
      apb(1'b1, 8'h04, 32'h1b);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("bp table", 4'h9, rd[5:2])
      apb(1'b1, 8'h04, 32'he4);
      i_far.levels(4'h0);
      apb(1'b1, 8'h00, 32'h5);
   endtask

   task automatic t_decode;
      slot_rd(0, 16'hff, 8, 8'h20);
      `CHK("mu zero", 16'h0, rd[15:0])
      apb(1'b1, 8'h00, 32'hd);
      slot_rd(0, 16'h1234, 16, 8'h20);
      `CHK("linear", 16'h1234, rd[15:0])
      apb(1'b1, 8'h00, 32'h5);
   endtask

   task automatic t_power;
      pwr_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK("standby", 1'b1, standby)
      `CHK("pd out", 1'b0, send_out)
      `CHK("pd rout", 1'b0, recv_out)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("pd word", 32'h0, rd)
      pwr_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      `CHK("awake", 1'b0, standby)
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // a hang ends the run as a mismatch
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         end_of_test;
      end
   end

   initial
   begin
      sys_rst = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      pwr_n   = 1'b1;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_slots;
      t_lock;
      t_width;
      t_bp;
      t_decode;
      t_power;
      end_of_test;
   end
endmodule
